// File: ifpll_vco_cal_map.svh
// register offsets, field positions, reset values and timing counts for the if pll and vco calibration bank
`ifndef IFPLL_VCO_CAL_MAP_SVH
`define IFPLL_VCO_CAL_MAP_SVH
// -----------------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------------
`define OFS_IF_FEEDBACK_DIVIDER 8'h3c
`define OFS_IF_REFERENCE_DIVIDER 8'h3d
`define OFS_IF_PUMP_AND_BIAS 8'h3e
`define OFS_CAL_CONTROL 8'h50
`define OFS_BIAS_CAL_SETTING 8'h51
`define OFS_BIAS_CAL_SETTLE 8'h52
`define OFS_RF_CAL_CODE 8'h53
`define OFS_RF_CAL_CYCLE_COUNT 8'h54
`define OFS_RF_CAL_SETTLE_TIMES 8'h55
`define OFS_RF_OSC_STARTUP_DELAY 8'h56
`define OFS_IF_CAL_CODE 8'h57
`define OFS_IF_CAL_CYCLE_COUNT 8'h58
`define OFS_IF_CAL_SETTLE_TIMES 8'h59
`define OFS_IF_FEEDBACK_DIVIDER_RB 8'hcc
`define OFS_IF_REFERENCE_DIVIDER_RB 8'hcd
`define OFS_IF_PUMP_AND_BIAS_RB 8'hce
// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define RST_IF_FEEDBACK_DIVIDER 16'h0080
`define RST_IF_REFERENCE_DIVIDER 16'h0002
`define RST_IF_PUMP_AND_BIAS 8'h00
`define RST_CAL_CONTROL 16'h1400
`define RST_BIAS_CAL_SETTING 8'h00
`define RST_BIAS_CAL_SETTLE 8'h06
`define RST_RF_CAL_CODE 16'h0000
`define RST_RF_CAL_CYCLE_COUNT 16'h015e
`define RST_RF_CAL_SETTLE_TIMES 16'h0d06
`define RST_RF_OSC_STARTUP_DELAY 16'h012c
`define RST_IF_CAL_CODE 16'h0000
`define RST_IF_CAL_CYCLE_COUNT 16'h01c2
`define RST_IF_CAL_SETTLE_TIMES 16'h0d0d
// -----------------------------------------------------------------------------
// field positions and writable masks
// -----------------------------------------------------------------------------
`define MSK_FEEDBACK_DIVIDER 16'h3fff
`define MSK_REFERENCE_DIVIDER 16'h01ff
`define MSK_PUMP_AND_BIAS 8'h8f
`define MSK_CAL_CONTROL 16'hff00
`define MSK_BIAS_CAL_SETTING 8'h1f
`define MSK_BIAS_CAL_SETTLE 8'h3f
`define MSK_CAL_CODE 16'h01ff
`define MSK_CAL_CYCLE_COUNT 16'h03ff
`define MSK_STARTUP_DELAY 16'h0fff
`define POS_OSC_BIAS_SELECT 7
`define POS_MHZ_LO 8
`define POS_IF_LAUNCH 2
`define POS_RF_LAUNCH 1
`define POS_BIAS_LAUNCH 0
// -----------------------------------------------------------------------------
// timing unit and pump current step
// -----------------------------------------------------------------------------
`define SETTLE_UNIT_US 8
`define PUMP_STEP_UA 25
`endif

// File: ifpll_vco_cal_pkg.sv
// types shared by the calibration register bank, its checker and its bench
package ifpll_vco_cal_pkg;
	// one register write or read request on the control port
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} reg_req_s;
	// calibration launch pulses
	typedef struct packed {
		logic if_osc;
		logic rf_osc;
		logic bias;
	} cal_launch_s;
	// if synthesiser settings handed to the analogue side
	typedef struct packed {
		logic [13:0] feedback_div;
		logic [8:0] reference_div;
		logic if_osc_bias_select;
		logic [3:0] pump_code;
	} if_synth_cfg_s;
endpackage : ifpll_vco_cal_pkg

// File: us_tick_divider.sv
// master clock divider that makes the one microsecond calibration tick
`timescale 1ns/10ps
module us_tick_divider (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic [7:0] master_clock_megahertz_in,
	output logic tick_out
);
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic tick_q;
	logic tick_d;
	logic [7:0] limit;

	// a value of zero is treated as one, the least legal figure
	always_comb
	begin
		limit = (master_clock_megahertz_in == 8'h00) ? 8'h01 : master_clock_megahertz_in;
		tick_d = 1'b0;
		count_d = count_q + 8'h01;
		if (count_q >= limit - 8'h01)
		begin
			count_d = 8'h00;
			tick_d = 1'b1;
		end
	end

	// register the count and the tick
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			count_q <= 8'h00;
			tick_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			tick_q <= tick_d;
		end
	end

	assign tick_out = tick_q;
endmodule : us_tick_divider

// File: ifpll_vco_cal_config_regs.sv
// if synthesiser and vco calibration configuration registers with readback and launch pulses
`timescale 1ns/10ps
`include "ifpll_vco_cal_map.svh"

// Behaviour
// - reference divider writes cross safely into the phase detector clock domain.
// - pump register bit 7 selects low (0, reset) or high oscillator bias.
// - pump code 0 to 15 means 25 to 400 microamps in steps of 25.
// - readback registers return the if synthesiser write registers unchanged.
// - master clock megahertz field, reset 20, divides to a microsecond tick.
// - writing one to control bit 2 launches if oscillator calibration.
// - writing one to control bit 1 launches rf oscillator calibration.
// - writing one to control bit 0 launches bias calibration.
// - bias setting is five bits; upper three bits reserved.
// - bias settle period is six bits of microseconds, reset 6.
// - rf open-loop count holds reference cycles, reset 350.
// - settle-time bytes count in units of eight microseconds.
// - rf start-up delay counts microseconds, reset 300.
// - if open-loop count holds reference cycles, reset 450.
module ifpll_vco_cal_config_regs (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic pd_clock_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output ifpll_vco_cal_pkg::if_synth_cfg_s if_cfg_out,
	output logic [8:0] pd_reference_div_out,
	output logic [8:0] pump_current_ua_out,
	output ifpll_vco_cal_pkg::cal_launch_s cal_launch_out,
	output logic us_tick_out,
	output logic [7:0] master_clock_megahertz_out,
	output logic [4:0] bias_cal_setting_out,
	output logic [5:0] bias_cal_settle_us_out,
	output logic [8:0] rf_cal_code_out,
	output logic [9:0] rf_cal_cycle_count_out,
	output logic [11:0] rf_loop_settle_us_out,
	output logic [11:0] rf_cal_settle_us_out,
	output logic [11:0] rf_osc_startup_us_out,
	output logic [8:0] if_cal_code_out,
	output logic [9:0] if_cal_cycle_count_out,
	output logic [11:0] if_loop_settle_us_out,
	output logic [11:0] if_cal_settle_us_out
);
	// -------------------------------------------------------------------------
	// register storage
	// -------------------------------------------------------------------------
	logic [15:0] fb_div_q, fb_div_d;
	logic [15:0] ref_div_q, ref_div_d;
	logic [7:0] pump_q, pump_d;
	logic [15:0] cal_ctrl_q, cal_ctrl_d;
	logic [7:0] bias_set_q, bias_set_d;
	logic [7:0] bias_settle_q, bias_settle_d;
	logic [15:0] rf_code_q, rf_code_d;
	logic [15:0] rf_count_q, rf_count_d;
	logic [15:0] rf_times_q, rf_times_d;
	logic [15:0] rf_startup_q, rf_startup_d;
	logic [15:0] if_code_q, if_code_d;
	logic [15:0] if_count_q, if_count_d;
	logic [15:0] if_times_q, if_times_d;
	ifpll_vco_cal_pkg::cal_launch_s launch_q, launch_d;
	logic [15:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic ref_toggle_q, ref_toggle_d;
	ifpll_vco_cal_pkg::reg_req_s req;

	// write strobe for one offset
	function automatic logic hit(input ifpll_vco_cal_pkg::reg_req_s r, input logic [7:0] ofs);
		hit = r.wr && (r.addr == ofs);
	endfunction : hit

	// eight microsecond units to microseconds
	function automatic logic [11:0] units8(input logic [7:0] v);
		units8 = {v, 4'h0} >> 1;
	endfunction : units8

	assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

	// -------------------------------------------------------------------------
	// write decode; reserved bits are stored as zero
	// -------------------------------------------------------------------------
	always_comb
	begin
		fb_div_d = hit(req, `OFS_IF_FEEDBACK_DIVIDER) ? (req.wdata & `MSK_FEEDBACK_DIVIDER) : fb_div_q;
		ref_div_d = hit(req, `OFS_IF_REFERENCE_DIVIDER) ? (req.wdata & `MSK_REFERENCE_DIVIDER) : ref_div_q;
		pump_d = hit(req, `OFS_IF_PUMP_AND_BIAS) ? (req.wdata[7:0] & `MSK_PUMP_AND_BIAS) : pump_q;
		cal_ctrl_d = hit(req, `OFS_CAL_CONTROL) ? (req.wdata & `MSK_CAL_CONTROL) : cal_ctrl_q;
		bias_set_d = hit(req, `OFS_BIAS_CAL_SETTING) ? (req.wdata[7:0] & `MSK_BIAS_CAL_SETTING) : bias_set_q;
		bias_settle_d = hit(req, `OFS_BIAS_CAL_SETTLE) ? (req.wdata[7:0] & `MSK_BIAS_CAL_SETTLE) : bias_settle_q;
		rf_code_d = hit(req, `OFS_RF_CAL_CODE) ? (req.wdata & `MSK_CAL_CODE) : rf_code_q;
		rf_count_d = hit(req, `OFS_RF_CAL_CYCLE_COUNT) ? (req.wdata & `MSK_CAL_CYCLE_COUNT) : rf_count_q;
		rf_times_d = hit(req, `OFS_RF_CAL_SETTLE_TIMES) ? req.wdata : rf_times_q;
		rf_startup_d = hit(req, `OFS_RF_OSC_STARTUP_DELAY) ? (req.wdata & `MSK_STARTUP_DELAY) : rf_startup_q;
		if_code_d = hit(req, `OFS_IF_CAL_CODE) ? (req.wdata & `MSK_CAL_CODE) : if_code_q;
		if_count_d = hit(req, `OFS_IF_CAL_CYCLE_COUNT) ? (req.wdata & `MSK_CAL_CYCLE_COUNT) : if_count_q;
		if_times_d = hit(req, `OFS_IF_CAL_SETTLE_TIMES) ? req.wdata : if_times_q;
		// launch bits are write-one pulses, never stored
		launch_d.if_osc = hit(req, `OFS_CAL_CONTROL) && req.wdata[`POS_IF_LAUNCH];
		launch_d.rf_osc = hit(req, `OFS_CAL_CONTROL) && req.wdata[`POS_RF_LAUNCH];
		launch_d.bias = hit(req, `OFS_CAL_CONTROL) && req.wdata[`POS_BIAS_LAUNCH];
		// a new reference divider is announced by a toggle
		ref_toggle_d = ref_toggle_q ^ hit(req, `OFS_IF_REFERENCE_DIVIDER);
	end

	// -------------------------------------------------------------------------
	// readback; write-only offsets and unmapped ones read as zero
	// -------------------------------------------------------------------------
	always_comb
	begin
		rvalid_d = req.rd;
		rdata_d = 16'h0000;
		if (req.rd)
		begin
			unique case (req.addr)
				`OFS_IF_FEEDBACK_DIVIDER_RB: rdata_d = fb_div_q;
				`OFS_IF_REFERENCE_DIVIDER_RB: rdata_d = ref_div_q;
				`OFS_IF_PUMP_AND_BIAS_RB: rdata_d = {8'h00, pump_q};
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	// register every system clock state of the bank
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			fb_div_q <= `RST_IF_FEEDBACK_DIVIDER;
			ref_div_q <= `RST_IF_REFERENCE_DIVIDER;
			pump_q <= `RST_IF_PUMP_AND_BIAS;
			cal_ctrl_q <= `RST_CAL_CONTROL;
			bias_set_q <= `RST_BIAS_CAL_SETTING;
			bias_settle_q <= `RST_BIAS_CAL_SETTLE;
			rf_code_q <= `RST_RF_CAL_CODE;
			rf_count_q <= `RST_RF_CAL_CYCLE_COUNT;
			rf_times_q <= `RST_RF_CAL_SETTLE_TIMES;
			rf_startup_q <= `RST_RF_OSC_STARTUP_DELAY;
			if_code_q <= `RST_IF_CAL_CODE;
			if_count_q <= `RST_IF_CAL_CYCLE_COUNT;
			if_times_q <= `RST_IF_CAL_SETTLE_TIMES;
			launch_q <= '0;
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
			ref_toggle_q <= 1'b0;
		end
		else
		begin
			fb_div_q <= fb_div_d;
			ref_div_q <= ref_div_d;
			pump_q <= pump_d;
			cal_ctrl_q <= cal_ctrl_d;
			bias_set_q <= bias_set_d;
			bias_settle_q <= bias_settle_d;
			rf_code_q <= rf_code_d;
			rf_count_q <= rf_count_d;
			rf_times_q <= rf_times_d;
			rf_startup_q <= rf_startup_d;
			if_code_q <= if_code_d;
			if_count_q <= if_count_d;
			if_times_q <= if_times_d;
			launch_q <= launch_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			ref_toggle_q <= ref_toggle_d;
		end
	end

	// -------------------------------------------------------------------------
	// phase detector domain: toggle synchroniser, then capture the stable word
	// -------------------------------------------------------------------------
	logic pd_sync1_q, pd_sync2_q, pd_seen_q;
	logic [8:0] pd_ref_q;
	logic [8:0] pd_ref_d;
	logic pd_seen_d;

	// the word is held steady while the toggle crosses, so it is safe to sample
	always_comb
	begin
		pd_seen_d = pd_sync2_q;
		pd_ref_d = (pd_sync2_q != pd_seen_q) ? ref_div_q[8:0] : pd_ref_q;
	end

	// two-flop synchroniser and capture register
	always_ff @(posedge pd_clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			pd_sync1_q <= 1'b0;
			pd_sync2_q <= 1'b0;
			pd_seen_q <= 1'b0;
			pd_ref_q <= 9'h002;
		end
		else
		begin
			pd_sync1_q <= ref_toggle_q;
			pd_sync2_q <= pd_sync1_q;
			pd_seen_q <= pd_seen_d;
			pd_ref_q <= pd_ref_d;
		end
	end

	// -------------------------------------------------------------------------
	// microsecond tick
	// -------------------------------------------------------------------------
	us_tick_divider tick_div (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.master_clock_megahertz_in(cal_ctrl_q[15:`POS_MHZ_LO]),
		.tick_out(us_tick_out)
	);

	// -------------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------------
	assign reg_rdata_out = rdata_q;
	assign reg_rvalid_out = rvalid_q;
	assign if_cfg_out.feedback_div = fb_div_q[13:0];
	assign if_cfg_out.reference_div = ref_div_q[8:0];
	assign if_cfg_out.if_osc_bias_select = pump_q[`POS_OSC_BIAS_SELECT];
	assign if_cfg_out.pump_code = pump_q[3:0];
	assign pd_reference_div_out = pd_ref_q;
	assign pump_current_ua_out = 9'({5'h00, pump_q[3:0]} + 9'h001) * 9'(`PUMP_STEP_UA);
	assign cal_launch_out = launch_q;
	assign master_clock_megahertz_out = cal_ctrl_q[15:8];
	assign bias_cal_setting_out = bias_set_q[4:0];
	assign bias_cal_settle_us_out = bias_settle_q[5:0];
	assign rf_cal_code_out = rf_code_q[8:0];
	assign rf_cal_cycle_count_out = rf_count_q[9:0];
	assign rf_loop_settle_us_out = units8(rf_times_q[15:8]);
	assign rf_cal_settle_us_out = units8(rf_times_q[7:0]);
	assign rf_osc_startup_us_out = rf_startup_q[11:0];
	assign if_cal_code_out = if_code_q[8:0];
	assign if_cal_cycle_count_out = if_count_q[9:0];
	assign if_loop_settle_us_out = units8(if_times_q[15:8]);
	assign if_cal_settle_us_out = units8(if_times_q[7:0]);
endmodule : ifpll_vco_cal_config_regs

// File: ifpll_vco_cal_config_regs_chk.sv
// concurrent checks on the ports of the if pll and vco calibration register bank
`timescale 1ns/10ps
module ifpll_vco_cal_config_regs_chk (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire ifpll_vco_cal_pkg::if_synth_cfg_s if_cfg_out,
	input wire logic [8:0] pump_current_ua_out,
	input wire ifpll_vco_cal_pkg::cal_launch_s cal_launch_out,
	input wire logic us_tick_out,
	input wire logic [7:0] master_clock_megahertz_out,
	input wire logic [4:0] bias_cal_setting_out,
	input wire logic [11:0] rf_loop_settle_us_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!arst_n_in);
	logic cal_wr;
	// a write to the calibration control register
	assign cal_wr = reg_wr_in && reg_addr_in == 8'h50;
	sequence s_quiet3;
		!us_tick_out [*3];
	endsequence
	sequence s_one_pulse;
		cal_launch_out.bias ##1 !cal_launch_out.bias;
	endsequence
	property p_read_valid; reg_rd_in |=> reg_rvalid_out; endproperty
	a_read_valid: assert property (p_read_valid) else $error("read valid missing");
	property p_fb_rb; reg_rd_in && reg_addr_in == 8'hcc |=> reg_rdata_out == {2'h0, if_cfg_out.feedback_div}; endproperty
	a_fb_rb: assert property (p_fb_rb) else $error("feedback readback wrong");
	property p_if_launch; cal_wr && reg_wdata_in[2] |=> cal_launch_out.if_osc; endproperty
	a_if_launch: assert property (p_if_launch) else $error("if launch missing");
	property p_rf_cause; cal_launch_out.rf_osc |-> $past(cal_wr && reg_wdata_in[1]); endproperty
	a_rf_cause: assert property (p_rf_cause) else $error("rf launch wrong");
	property p_bias_launch; cal_wr && reg_wdata_in[0] |=> s_one_pulse; endproperty
	a_bias_launch: assert property (p_bias_launch) else $error("bias launch wrong");
	property p_pump_ua; pump_current_ua_out == 9'((if_cfg_out.pump_code + 5'h01) * 9'h019); endproperty
	a_pump_ua: assert property (p_pump_ua) else $error("pump current wrong");
	property p_mhz; cal_wr |=> master_clock_megahertz_out == $past(reg_wdata_in[15:8]); endproperty
	a_mhz: assert property (p_mhz) else $error("clock field wrong");
	property p_tick_gap; us_tick_out && master_clock_megahertz_out == 8'h04 |=> s_quiet3 ##1 us_tick_out; endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
	property p_bias_set; reg_wr_in && reg_addr_in == 8'h51 |=> bias_cal_setting_out == $past(reg_wdata_in[4:0]); endproperty
	a_bias_set: assert property (p_bias_set) else $error("bias setting wrong");
	property p_settle; reg_wr_in && reg_addr_in == 8'h55 |=> rf_loop_settle_us_out == {1'h0, $past(reg_wdata_in[15:8]), 3'h0};
	endproperty
	a_settle: assert property (p_settle) else $error("settle time wrong");
endmodule : ifpll_vco_cal_config_regs_chk
bind ifpll_vco_cal_config_regs ifpll_vco_cal_config_regs_chk chk_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .if_cfg_out(if_cfg_out),
	.pump_current_ua_out(pump_current_ua_out), .cal_launch_out(cal_launch_out), .us_tick_out(us_tick_out),
	.master_clock_megahertz_out(master_clock_megahertz_out), .bias_cal_setting_out(bias_cal_setting_out),
	.rf_loop_settle_us_out(rf_loop_settle_us_out));

// File: tb_ifpll_vco_cal_config_regs.sv
// self-checking bench for the if pll and vco calibration register bank
`timescale 1ns/10ps
module tb_ifpll_vco_cal_config_regs;
	logic clock_in = 1'b0;
	logic pd_clock_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic [15:0] reg_rdata_out, rd_val;
	logic reg_rvalid_out, us_tick_out;
	ifpll_vco_cal_pkg::if_synth_cfg_s if_cfg_out;
	ifpll_vco_cal_pkg::cal_launch_s cal_launch_out, launch_seen;
	logic [8:0] pd_reference_div_out, pump_current_ua_out;
	logic [7:0] master_clock_megahertz_out;
	logic [4:0] bias_cal_setting_out;
	logic [5:0] bias_settle;
	logic [9:0] rf_count, if_count;
	logic [8:0] rf_code, if_code;
	logic [11:0] rf_loop, rf_cal, rf_start, if_loop, if_cal;
	int error_cnt = 0;
	int checks_done = 0;
	int cycles = 0;
	ifpll_vco_cal_config_regs DUT (.clock_in(clock_in), .arst_n_in(arst_n_in), .pd_clock_in(pd_clock_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .if_cfg_out(if_cfg_out),
		.pd_reference_div_out(pd_reference_div_out), .pump_current_ua_out(pump_current_ua_out),
		.cal_launch_out(cal_launch_out), .us_tick_out(us_tick_out),
		.master_clock_megahertz_out(master_clock_megahertz_out), .bias_cal_setting_out(bias_cal_setting_out),
		.bias_cal_settle_us_out(bias_settle), .rf_cal_code_out(rf_code), .rf_cal_cycle_count_out(rf_count),
		.rf_loop_settle_us_out(rf_loop), .rf_cal_settle_us_out(rf_cal), .rf_osc_startup_us_out(rf_start),
		.if_cal_code_out(if_code), .if_cal_cycle_count_out(if_count), .if_loop_settle_us_out(if_loop),
		.if_cal_settle_us_out(if_cal));
	// system clock and an unrelated phase detector clock
	initial forever #12.5 clock_in = ~clock_in;
	initial forever #18.7 pd_clock_in = ~pd_clock_in;
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	// hang guard
	always @(posedge clock_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			error_cnt++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one write, then catch the launch pulses of the following cycle
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
		#1 launch_seen = cal_launch_out;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clock_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		#1 rd_val = reg_rdata_out;
		chk("rvalid", 16'h0001, 16'(reg_rvalid_out));
		chk("rdata", exp, rd_val);
	endtask : rd
	task automatic t_reset();
		rd(8'hcc, 16'h0080);
		rd(8'hcd, 16'h0002);
		rd(8'hce, 16'h0000);
		chk("mhz", 16'h0014, 16'(master_clock_megahertz_out));
		chk("bias settle", 16'h0006, 16'(bias_settle));
		chk("rf count", 16'h015e, 16'(rf_count));
		chk("rf loop", 16'h0068, 16'(rf_loop));
		chk("rf cal", 16'h0030, 16'(rf_cal));
		chk("if loop", 16'h0068, 16'(if_loop));
		chk("if cal", 16'h0068, 16'(if_cal));
		chk("startup", 16'h012c, 16'(rf_start));
		chk("if count", 16'h01c2, 16'(if_count));
		chk("pd ref", 16'h0002, 16'(pd_reference_div_out));
		chk("bias sel", 16'h0000, 16'(if_cfg_out.if_osc_bias_select));
	endtask : t_reset
	task automatic t_synth();
		wr(8'h3c, 16'h0019);
		rd(8'hcc, 16'h0019);
		wr(8'h3c, 16'h3fff);
		rd(8'hcc, 16'h3fff);
		for (int i = 0; i < 16; i++)
		begin
			wr(8'h3e, 16'(i));
			chk("pump ua", 16'((i + 1) * 25), 16'(pump_current_ua_out));
		end
		wr(8'h3e, 16'h008f);
		chk("bias sel", 16'h0001, 16'(if_cfg_out.if_osc_bias_select));
		rd(8'hce, 16'h008f);
		rd(8'h3c, 16'h0000);
		rd(8'h77, 16'h0000);
		wr(8'h3d, 16'h01ff);
		rd(8'hcd, 16'h01ff);
		wr(8'h3d, 16'h0005);
		for (int n = 0; n < 40 && pd_reference_div_out !== 9'h005; n++)
			@(posedge clock_in);
		chk("pd ref", 16'h0005, 16'(pd_reference_div_out));
	endtask : t_synth
	task automatic t_launch();
		int gap;
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h50, 16'h0400 | 16'(1 << i));
			chk("launch", 16'(1 << i), 16'(launch_seen));
			chk("mhz", 16'h0004, 16'(master_clock_megahertz_out));
		end
		wr(8'h50, 16'h0400);
		chk("no launch", 16'h0000, 16'(launch_seen));
		for (int n = 0; n < 50 && us_tick_out !== 1'b1; n++)
			@(posedge clock_in) #1;
		gap = 0;
		do
		begin
			@(posedge clock_in) #1;
			gap++;
		end
		while (us_tick_out !== 1'b1 && gap < 50);
		chk("tick gap", 16'h0004, 16'(gap));
	endtask : t_launch
	task automatic t_cal();
		wr(8'h51, 16'h00ff);
		chk("bias set", 16'h001f, 16'(bias_cal_setting_out));
		wr(8'h52, 16'h003f);
		chk("bias settle", 16'h003f, 16'(bias_settle));
		wr(8'h54, 16'h0023);
		chk("rf count", 16'h0023, 16'(rf_count));
		wr(8'h58, 16'h012c);
		chk("if count", 16'h012c, 16'(if_count));
		wr(8'h55, 16'h0102);
		chk("rf loop", 16'h0008, 16'(rf_loop));
		chk("rf cal", 16'h0010, 16'(rf_cal));
		wr(8'h59, 16'hff01);
		chk("if loop", 16'h07f8, 16'(if_loop));
		wr(8'h56, 16'h0fff);
		chk("startup", 16'h0fff, 16'(rf_start));
		chk("if cal", 16'h0008, 16'(if_cal));
		wr(8'h53, 16'hffff);
		chk("rf code", 16'h01ff, 16'(rf_code));
		wr(8'h57, 16'h00a5);
		chk("if code", 16'h00a5, 16'(if_code));
		chk("rf code kept", 16'h01ff, 16'(rf_code));
	endtask : t_cal
	initial
	begin
		repeat (8) @(posedge clock_in);
		arst_n_in <= 1'b1;
		t_reset();
		t_synth();
		t_launch();
		t_cal();
		close_out();
	end
endmodule : tb_ifpll_vco_cal_config_regs
